// File: verilog/dhl_pkg.sv
package dhl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the ahb-lite slave
  localparam logic [31:0] OFS_DIAL_IO  = 32'h0000_0000;
  localparam logic [31:0] OFS_IRQ_STAT = 32'h0000_0004;
  localparam logic [31:0] OFS_IRQ_MASK = 32'h0000_0008;
  localparam logic [31:0] OFS_PWR_MODE = 32'h0000_000C;
  localparam logic [31:0] OFS_IRQ_VEC  = 32'h0000_0010;

  // dialer io register fields
  localparam int BIT_HF_REQ   = 0;
  localparam int BIT_HF_OUT   = 1;
  localparam int BIT_HOLD_REQ = 2;
  localparam int BIT_HOLD_OUT = 3;
  localparam int BIT_HOOK     = 4;
  localparam int BIT_AUTO_SEL = 5;
  localparam int BIT_LSW      = 6;
  localparam int BIT_MUTE     = 7;
  localparam int BIT_LSW_PIN  = 8;
  localparam int BIT_MUTE_PIN = 9;

  // interrupt status and mask fields
  localparam int EV_HOOK_ON  = 0;
  localparam int EV_HOOK_OFF = 1;
  localparam int EV_HOLD     = 2;
  localparam int EV_HF       = 3;
  localparam int EV_W        = 4;

  // operating modes
  localparam int         PM_W      = 2;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_GREEN  = 2'h1;
  localparam logic [1:0] PM_SLEEP  = 2'h2;
  localparam logic [1:0] PM_IDLE   = 2'h3;

  localparam logic [7:0] DIALER_VECTOR = 8'h18;

  // reset values
  localparam logic            RST_AUTO_SEL = 1'h0;
  localparam logic            RST_LSW_DRV  = 1'h0;
  localparam logic            RST_MUTE_DRV = 1'h0;
  localparam logic [EV_W-1:0] RST_IRQ_MASK = 4'h0;

  // pin sampler: index and idle level of each input
  localparam int         IN_HF   = 0;
  localparam int         IN_HOLD = 1;
  localparam int         IN_HOOK = 2;
  localparam int         IN_W    = 3;
  localparam logic [2:0] PIN_RST = 3'h6;

  // ahb-lite
  localparam int         HTRANS_ACT_BIT = 1;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;
  localparam logic       HRESP_OKAY     = 1'h0;

  typedef enum logic {HK_ON, HK_OFF} dhl_hook_t;

endpackage

// File: verilog/dhl_evt_if.sv
`timescale 1ns/100ps
interface dhl_evt_if;
  logic [2:0] lvl;
  logic       hook_rise;
  logic       hook_fall;
  logic       hf_pulse;
  logic       hold_pulse;
  modport src (output lvl, hook_rise, hook_fall, hf_pulse, hold_pulse);
  modport dst (input lvl, hook_rise, hook_fall, hf_pulse, hold_pulse);
endinterface

// File: verilog/dhl_pin_sync.sv
`timescale 1ns/100ps
module dhl_pin_sync
  import dhl_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [IN_W-1:0] pins_in,
  dhl_evt_if.src               evt
);

  typedef struct packed {
    logic [IN_W-1:0] s1;
    logic [IN_W-1:0] s2;
    logic [IN_W-1:0] s3;
  } dhl_sync_t;

  dhl_sync_t st_r;
  dhl_sync_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // s1 feeds only s2; edges are seen between s2 and s3
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins_in;      // [RULE16]
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '{s1: PIN_RST, s2: PIN_RST, s3: PIN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign evt.lvl        = st_r.s2;
  assign evt.hook_rise  = st_r.s2[IN_HOOK] & ~st_r.s3[IN_HOOK];
  assign evt.hook_fall  = ~st_r.s2[IN_HOOK] & st_r.s3[IN_HOOK];
  assign evt.hf_pulse   = st_r.s2[IN_HF] & ~st_r.s3[IN_HF];
  assign evt.hold_pulse = ~st_r.s2[IN_HOLD] & st_r.s3[IN_HOLD];

  ////////////////////////////////////////////////////////////////////////////
  pulse_single_a : assert property (@(posedge clk_in) disable iff (rst_in) // [RULE16]
    evt.hf_pulse |=> !evt.hf_pulse)
    else $error("hand-free request pulse longer than one cycle");

endmodule

// File: verilog/dhl_irq.sv
`timescale 1ns/100ps
module dhl_irq
  import dhl_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_in,
  input  wire logic [EV_W-1:0] set_in,
  input  wire logic [EV_W-1:0] clr_in,
  input  wire logic            mask_wr_in,
  input  wire logic [EV_W-1:0] mask_in,
  output logic      [EV_W-1:0] stat_out,
  output logic      [EV_W-1:0] mask_out,
  output logic                 irq_out
);

  typedef struct packed {
    logic [EV_W-1:0] stat;
    logic [EV_W-1:0] mask;
    logic            irq;
  } dhl_irq_t;

  dhl_irq_t st_r;
  dhl_irq_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt      = st_r;
    // set beats a write-one-to-clear in the same cycle
    st_nxt.stat = (st_r.stat & ~clr_in) | set_in;       // [RULE17]
    if (mask_wr_in) begin
      st_nxt.mask = mask_in;
    end
    st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= '{stat: '0, mask: RST_IRQ_MASK, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat_out = st_r.stat;
  assign mask_out = st_r.mask;
  assign irq_out  = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  irq_level_a : assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
    irq_out == |(stat_out & mask_out))
    else $error("interrupt output disagrees with status and mask");

  set_wins_a : assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
    (set_in != '0) |=> ((stat_out & $past(set_in)) == $past(set_in)))
    else $error("interrupt event lost");

endmodule

// File: verilog/dhl_dialer_io.sv
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// RULE1 - mute pin pulled low while software says dialing
// RULE2 - line switch pin follows software bit only
// RULE3 - line power high makes, low breaks line
// RULE4 - hook rise: on-hook status, raise interrupt
// RULE5 - hook fall: off-hook, clear hand-free, hold, interrupt
// RULE6 - hold-line set keeps line power high
// RULE7 - hold request low pulse: clear hand-free, toggle hold
// RULE8 - hold request ignored unless line made
// RULE9 - hand-free set drives line power high
// RULE10 - hand-free pulse: clear hold, toggle hand-free, interrupt
// RULE11 - hook pin high on-hook, low off-hook
// RULE12 - auto select zero forces line power low
// RULE13 - line power low only on-hook, no hand-free/hold
// RULE14 - on-hook with hold: hold request no interrupt
// RULE15 - dialer logic frozen in idle mode; here line power still follows the hook pin level
// RULE16 - synchronise inputs before edge and pulse detection
// RULE17 - sticky dialer interrupt flag, cleared by service
module dhl_dialer_io
  import dhl_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        HOOK_SWITCH_IN,
  input  wire logic        HANDSFREE_REQUEST_IN,
  input  wire logic        HOLD_REQUEST_IN,
  output logic             LINE_POWER_OUT,
  output logic             HANDSFREE_OUT,
  output logic             HOLD_LINE_OUT,
  input  wire logic        SPEECH_MUTE_IN,
  output logic             SPEECH_MUTE_OUT,
  output logic             SPEECH_MUTE_OE_OUT,
  input  wire logic        LINE_SWITCH_IN,
  output logic             LINE_SWITCH_OUT,
  output logic             LINE_SWITCH_OE_OUT,
  output logic             DIALER_IRQ_OUT
);

  typedef struct packed {
    logic        dp_act;
    logic        dp_wr;
    logic [31:0] dp_adr;
    logic        rdy;
    logic [31:0] rdata;
    logic        auto_sel;
    logic        lsw_drv;
    logic        mute_drv;
    logic [1:0]  pmode;
    dhl_hook_t   dial_st;
    logic        hook_lvl;
    logic        hf;
    logic        hd;
    logic        po;
  } dhl_main_t;

  localparam dhl_main_t MAIN_RST = '{
    dp_act:   1'b0,
    dp_wr:    1'b0,
    dp_adr:   OFS_DIAL_IO,
    rdy:      1'b1,
    rdata:    32'h0000_0000,
    auto_sel: RST_AUTO_SEL,
    lsw_drv:  RST_LSW_DRV,
    mute_drv: RST_MUTE_DRV,
    pmode:    PM_NORMAL,
    dial_st:  HK_ON,
    hook_lvl: PIN_RST[IN_HOOK],
    hf:       1'b0,
    hd:       1'b0,
    po:       1'b0
  };

  dhl_main_t       st_r;
  dhl_main_t       st_nxt;
  dhl_evt_if       evt ();
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] stat_fw;
  logic [EV_W-1:0] mask_fw;
  logic            irq_lvl;
  logic            wr_io;
  logic            wr_stat;
  logic            wr_mask;
  logic            wr_mode;
  logic            active;
  logic            hold_quiet;
  logic            addr_go;

  ////////////////////////////////////////////////////////////////////////////
  // input sampling and interrupt flags
  dhl_pin_sync u_sync (
    .clk_in  (CLK_IN),
    .rst_in  (SYS_RST_IN),
    .pins_in ({HOOK_SWITCH_IN, HOLD_REQUEST_IN, HANDSFREE_REQUEST_IN}),
    .evt     (evt.src)
  );

  dhl_irq u_irq (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .set_in     (ev_set),
    .clr_in     (ev_clr),
    .mask_wr_in (wr_mask),
    .mask_in    (HWDATA_IN[EV_W-1:0]),
    .stat_out   (irq_stat),
    .mask_out   (irq_mask),
    .irq_out    (irq_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode; writes land at the end of the data phase
  assign wr_io   = st_r.dp_act & st_r.dp_wr & (st_r.dp_adr == OFS_DIAL_IO);
  assign wr_stat = st_r.dp_act & st_r.dp_wr & (st_r.dp_adr == OFS_IRQ_STAT);
  assign wr_mask = st_r.dp_act & st_r.dp_wr & (st_r.dp_adr == OFS_IRQ_MASK);
  assign wr_mode = st_r.dp_act & st_r.dp_wr & (st_r.dp_adr == OFS_PWR_MODE);
  assign addr_go = HSEL_IN & HREADY_IN & HTRANS_IN[HTRANS_ACT_BIT];
  assign ev_clr  = wr_stat ? HWDATA_IN[EV_W-1:0] : '0;
  // forwarded values so a read right behind a write sees the new data
  assign stat_fw = (irq_stat & ~ev_clr) | ev_set;
  assign mask_fw = wr_mask ? HWDATA_IN[EV_W-1:0] : irq_mask;
  assign active  = (st_r.pmode != PM_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt     = st_r;
    ev_set     = '0;
    hold_quiet = 1'b0;

    if (wr_io) begin
      st_nxt.auto_sel = HWDATA_IN[BIT_AUTO_SEL];
      st_nxt.lsw_drv  = ~HWDATA_IN[BIT_LSW];              // [RULE2]
      st_nxt.mute_drv = ~HWDATA_IN[BIT_MUTE];             // [RULE1]
    end
    if (wr_mode) begin
      st_nxt.pmode = HWDATA_IN[PM_W-1:0];
    end

    case (st_r.dial_st)
      HK_ON:   hold_quiet = st_r.hd;                      // [RULE14]
      HK_OFF:  hold_quiet = 1'b0;
      default: hold_quiet = 1'b0;
    endcase

    st_nxt.hook_lvl = evt.lvl[IN_HOOK];
    // idle mode: events pass by without effect
    if (active) begin                                     // [RULE15]
      if (evt.hf_pulse) begin
        st_nxt.hd      = 1'b0;                            // [RULE10]
        st_nxt.hf      = ~st_nxt.hf;
        ev_set[EV_HF]  = 1'b1;
      end
      // only while the line is made
      if (evt.hold_pulse && st_r.po) begin                // [RULE8]
        st_nxt.hf       = 1'b0;                           // [RULE7]
        st_nxt.hd       = ~st_nxt.hd;
        ev_set[EV_HOLD] = ~hold_quiet;                    // [RULE14]
      end
      if (evt.hook_rise) begin
        st_nxt.dial_st     = HK_ON;                       // [RULE4]
        ev_set[EV_HOOK_ON] = 1'b1;
      end
      // hook fall last so it overrides any request in the same cycle
      if (evt.hook_fall) begin
        st_nxt.dial_st      = HK_OFF;                     // [RULE5]
        st_nxt.hf           = 1'b0;
        st_nxt.hd           = 1'b0;
        ev_set[EV_HOOK_OFF] = 1'b1;
      end
    end

    // on-hook level high; hand-free or hold keeps the line made
    st_nxt.po = st_nxt.auto_sel                           // [RULE12] [RULE11]
              & (~st_nxt.hook_lvl | st_nxt.hf | st_nxt.hd); // [RULE3] [RULE6] [RULE9] [RULE13]

    // address phase; a write of anything but a word is ignored, reads of any size are answered
    st_nxt.dp_act = addr_go;
    st_nxt.dp_wr  = HWRITE_IN & (HSIZE_IN == HSIZE_WORD);
    st_nxt.dp_adr = HADDR_IN;
    st_nxt.rdy    = 1'b1;
    st_nxt.rdata  = '0;
    if (addr_go && !HWRITE_IN) begin
      case (HADDR_IN)
        OFS_DIAL_IO: begin
          st_nxt.rdata[BIT_HF_REQ]   = evt.lvl[IN_HF];
          st_nxt.rdata[BIT_HF_OUT]   = st_nxt.hf;
          st_nxt.rdata[BIT_HOLD_REQ] = evt.lvl[IN_HOLD];
          st_nxt.rdata[BIT_HOLD_OUT] = st_nxt.hd;
          st_nxt.rdata[BIT_HOOK]     = st_nxt.hook_lvl;
          st_nxt.rdata[BIT_AUTO_SEL] = st_nxt.auto_sel;
          st_nxt.rdata[BIT_LSW]      = ~st_nxt.lsw_drv;
          st_nxt.rdata[BIT_MUTE]     = ~st_nxt.mute_drv;
          st_nxt.rdata[BIT_LSW_PIN]  = LINE_SWITCH_IN;
          st_nxt.rdata[BIT_MUTE_PIN] = SPEECH_MUTE_IN;
        end
        OFS_IRQ_STAT: st_nxt.rdata[EV_W-1:0] = stat_fw;
        OFS_IRQ_MASK: st_nxt.rdata[EV_W-1:0] = mask_fw;
        OFS_PWR_MODE: st_nxt.rdata[PM_W-1:0] = st_nxt.pmode;
        OFS_IRQ_VEC:  st_nxt.rdata[7:0]      = DIALER_VECTOR;
        default:      st_nxt.rdata           = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      st_r <= MAIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open-drain pins only ever pull low
  assign HRDATA_OUT         = st_r.rdata;
  assign HREADYOUT_OUT      = st_r.rdy;
  assign HRESP_OUT          = HRESP_OKAY;
  assign LINE_POWER_OUT     = st_r.po;
  assign HANDSFREE_OUT      = st_r.hf;
  assign HOLD_LINE_OUT      = st_r.hd;
  assign SPEECH_MUTE_OUT    = 1'b0;
  assign SPEECH_MUTE_OE_OUT = st_r.mute_drv;
  assign LINE_SWITCH_OUT    = 1'b0;
  assign LINE_SWITCH_OE_OUT = st_r.lsw_drv;
  assign DIALER_IRQ_OUT     = irq_lvl;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);

  mute_pin_a : assert property (wr_io |=> SPEECH_MUTE_OE_OUT == !$past(HWDATA_IN[BIT_MUTE])) // [RULE1]
    else $error("mute pin does not follow software");

  line_sw_a : assert property (!wr_io |=> $stable(LINE_SWITCH_OE_OUT)) // [RULE2]
    else $error("line switch pin moved without a write");

  po_forced_a : assert property (!st_r.auto_sel |-> !LINE_POWER_OUT) // [RULE12]
    else $error("line power high with automatic control off");

  po_combo_a : assert property (st_r.auto_sel |-> // [RULE13]
    LINE_POWER_OUT == (!st_r.hook_lvl || HANDSFREE_OUT || HOLD_LINE_OUT))
    else $error("line power wrong for hook and request state");

  hook_rise_a : assert property ((active && evt.hook_rise) |=> irq_stat[EV_HOOK_ON] // [RULE4]
    && st_r.dial_st == HK_ON)
    else $error("hook rise not taken");

  hook_fall_a : assert property ((active && evt.hook_fall) |=> !HANDSFREE_OUT // [RULE5]
    && !HOLD_LINE_OUT && irq_stat[EV_HOOK_OFF] && st_r.dial_st == HK_OFF)
    else $error("hook fall did not clear hand-free and hold");

  hf_toggle_a : assert property ((active && evt.hf_pulse && !evt.hook_fall && !evt.hold_pulse) // [RULE10]
    |=> HANDSFREE_OUT != $past(HANDSFREE_OUT) && !HOLD_LINE_OUT && irq_stat[EV_HF])
    else $error("hand-free request not handled");

  hold_gate_a : assert property ((evt.hold_pulse && !LINE_POWER_OUT && !evt.hook_fall && !evt.hf_pulse) // [RULE8]
    |=> $stable(HOLD_LINE_OUT))
    else $error("hold request acted on a broken line");

  hold_quiet_a : assert property ((evt.hold_pulse && st_r.dial_st == HK_ON && HOLD_LINE_OUT) // [RULE14]
    |-> !ev_set[EV_HOLD])
    else $error("hold request interrupt raised while on-hook with hold");

  idle_freeze_a : assert property (!active |=> $stable(HANDSFREE_OUT) && $stable(HOLD_LINE_OUT)) // [RULE15]
    else $error("dialer state changed in idle mode");

  rst_values_a : assert property ($fell(SYS_RST_IN) |-> // [RULE12]
    !LINE_POWER_OUT && !HANDSFREE_OUT && !HOLD_LINE_OUT && !DIALER_IRQ_OUT && !SPEECH_MUTE_OE_OUT)
    else $error("outputs not at reset values");

  vec_read_a : assert property ((addr_go && !HWRITE_IN && HADDR_IN == OFS_IRQ_VEC) |=> // [RULE4]
    HRDATA_OUT[7:0] == DIALER_VECTOR)
    else $error("interrupt vector reads wrong");

  mute_hold_a : assert property (!wr_io |=> // [RULE1]
    $stable(SPEECH_MUTE_OE_OUT))
    else $error("mute pin moved without a write");

  line_sw_wr_a : assert property (wr_io |=> // [RULE2]
    LINE_SWITCH_OE_OUT == !$past(HWDATA_IN[BIT_LSW]))
    else $error("line switch pin does not follow software");

  po_make_a : assert property ((st_r.auto_sel && !st_r.hook_lvl) |-> // [RULE3]
    LINE_POWER_OUT)
    else $error("line broken while off-hook");

  hold_po_a : assert property ((st_r.auto_sel && HOLD_LINE_OUT) |-> // [RULE6]
    LINE_POWER_OUT)
    else $error("hold-line set but line broken");

  hf_po_a : assert property ((st_r.auto_sel && HANDSFREE_OUT) |-> // [RULE9]
    LINE_POWER_OUT)
    else $error("hand-free set but line broken");

  po_break_a : assert property ( // [RULE13]
    (st_r.auto_sel && st_r.hook_lvl && !HANDSFREE_OUT && !HOLD_LINE_OUT) |-> !LINE_POWER_OUT)
    else $error("line made while on-hook with nothing held");

  po_auto_off_a : assert property ((wr_io && !HWDATA_IN[BIT_AUTO_SEL]) |=> // [RULE12]
    !LINE_POWER_OUT)
    else $error("line power not forced low");

  hold_toggle_a : assert property ( // [RULE7]
    (active && evt.hold_pulse && st_r.po && !evt.hf_pulse && !evt.hook_fall)
    |=> HOLD_LINE_OUT != $past(HOLD_LINE_OUT) && !HANDSFREE_OUT)
    else $error("hold request not handled");

  hold_irq_a : assert property ((active && evt.hold_pulse && st_r.po && !hold_quiet) |=> // [RULE7]
    irq_stat[EV_HOLD])
    else $error("hold request interrupt missing");

  hold_ign_irq_a : assert property ((evt.hold_pulse && !st_r.po) |-> // [RULE8]
    !ev_set[EV_HOLD])
    else $error("hold request on broken line raised interrupt");

  hf_irq_a : assert property ((active && evt.hf_pulse) |=> // [RULE10]
    irq_stat[EV_HF])
    else $error("hand-free request interrupt missing");

  hf_clr_hold_a : assert property ((active && evt.hf_pulse && !evt.hold_pulse) |=> // [RULE10]
    !HOLD_LINE_OUT)
    else $error("hand-free request left hold set");

  rise_keep_a : assert property ( // [RULE4]
    (active && evt.hook_rise && !evt.hf_pulse && !evt.hold_pulse)
    |=> $stable(HANDSFREE_OUT) && $stable(HOLD_LINE_OUT))
    else $error("hook rise changed hand-free or hold");

  idle_quiet_a : assert property (!active |-> // [RULE15]
    ev_set == '0)
    else $error("event raised in idle mode");

  idle_dial_a : assert property (!active |=> // [RULE15]
    $stable(st_r.dial_st))
    else $error("dialer status changed in idle mode");

  hook_sync_a : assert property (evt.hook_rise |-> // [RULE16]
    $past(HOOK_SWITCH_IN, 2) && !$past(HOOK_SWITCH_IN, 3))
    else $error("hook rise not two stages behind the pin");

  stat_clr_a : assert property ((wr_stat && ev_set == '0) |=> // [RULE17]
    (irq_stat & $past(HWDATA_IN[EV_W-1:0])) == '0)
    else $error("status bit not cleared by write");

endmodule

// File: tb/dhl_line_model.sv
`timescale 1ns/100ps
module dhl_line_model (
  input  wire logic clk_in,
  input  wire logic mute_drv_in,
  input  wire logic mute_oe_in,
  input  wire logic lsw_drv_in,
  input  wire logic lsw_oe_in,
  output logic      hook_out,
  output logic      hf_out,
  output logic      hold_out,
  output logic      mute_pin_out,
  output logic      lsw_pin_out
);
  ////////////////////////////////////////////////////////////////////////////
  // both open-drain lines carry pull-ups, so a released pin reads high
  assign mute_pin_out = mute_oe_in ? mute_drv_in : 1'b1;
  assign lsw_pin_out  = lsw_oe_in ? lsw_drv_in : 1'b1;

  initial begin
    hook_out = 1'b1;
    hf_out   = 1'b0;
    hold_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // high on-hook, low off-hook
  task automatic set_hook(input logic v);
    hook_out <= v;
    @(posedge clk_in);
  endtask

  // button widths vary so slow and quick presses both occur
  task automatic press_hf(input int w);
    hf_out <= 1'b1;
    repeat (w) @(posedge clk_in);
    hf_out <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic press_hold(input int w);
    hold_out <= 1'b0;
    repeat (w) @(posedge clk_in);
    hold_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule

// File: tb/dialer_hook_line_io_bench.sv
`timescale 1ns/100ps
module dialer_hook_line_io_bench;
  import dhl_pkg::*;
  logic            clk = 1'b0;
  logic            rst = 1'b1;
  logic            hsel = 1'b0;
  logic            hwrite = 1'b0;
  logic [1:0]      htrans = 2'h0;
  logic [2:0]      hsize = 3'h0;
  logic [31:0]     haddr = 32'h0000_0000;
  logic [31:0]     hwdata = 32'h0000_0000;
  logic [31:0]     hrdata;
  logic            hready, hresp, hook, hf_req, hold_req, line_pwr, hf_o, hold_o;
  logic            mute_pin, mute_o, mute_oe, lsw_pin, lsw_o, lsw_oe, irq;
  logic            hf_e, hold_e, hook_lvl, hook_on, auto_e, mute_e, lsw_e;
  logic [EV_W-1:0] st_e, mask_e;
  logic [1:0]      mode_e;
  integer          seed = 43145;
  int              n_fail = 0;
  int              cmp_count = 0;
  int              dseq[9] = '{1, 0, 1, 2, 1, 2, 1, 0, 0};

  always #2.5 clk = ~clk;

  dhl_dialer_io dut (.CLK_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .HOOK_SWITCH_IN(hook), .HANDSFREE_REQUEST_IN(hf_req),
    .HOLD_REQUEST_IN(hold_req), .LINE_POWER_OUT(line_pwr), .HANDSFREE_OUT(hf_o), .HOLD_LINE_OUT(hold_o),
    .SPEECH_MUTE_IN(mute_pin), .SPEECH_MUTE_OUT(mute_o), .SPEECH_MUTE_OE_OUT(mute_oe),
    .LINE_SWITCH_IN(lsw_pin), .LINE_SWITCH_OUT(lsw_o), .LINE_SWITCH_OE_OUT(lsw_oe), .DIALER_IRQ_OUT(irq));

  dhl_line_model lm (.clk_in(clk), .mute_drv_in(mute_o), .mute_oe_in(mute_oe), .lsw_drv_in(lsw_o),
    .lsw_oe_in(lsw_oe), .hook_out(hook), .hf_out(hf_req), .hold_out(hold_req), .mute_pin_out(mute_pin),
    .lsw_pin_out(lsw_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // samples at the falling edge what stands at the coming rising edge
  task automatic wait_rdy(output logic [31:0] d);
    int k;
    logic r;
    k = 0;
    do begin
      @(negedge clk);
      r = hready;
      d = hrdata;
      @(posedge clk);
      k++;
    end while (r !== 1'b1 && k < 40);
    if (r !== 1'b1) begin
      n_fail++;
      tally_and_finish;
    end
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] x;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    wait_rdy(x);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r & msk, exp);
  endtask

  task automatic set_io(input logic a, input logic l, input logic m);
    wr(OFS_DIAL_IO, {24'h0, m, l, a, 5'h0});
    auto_e = a;
    lsw_e = ~l;
    mute_e = ~m;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_po();
    return auto_e & (~hook_lvl | hf_e | hold_e);
  endfunction

  // kind 0 hand-free press, 1 hold press, 2 hook toggle
  task automatic model_ev(input int kind);
    if (mode_e == PM_IDLE) begin
      if (kind == 2) hook_lvl = ~hook_lvl;
      return;
    end
    case (kind)
      0: begin
        hold_e = 1'b0;
        hf_e = ~hf_e;
        st_e[EV_HF] = 1'b1;
      end
      1: if (exp_po()) begin
        if (!(hook_on && hold_e)) st_e[EV_HOLD] = 1'b1;
        hf_e = 1'b0;
        hold_e = ~hold_e;
      end
      default: begin
        hook_lvl = ~hook_lvl;
        hook_on = hook_lvl;
        if (hook_lvl) st_e[EV_HOOK_ON] = 1'b1;
        else begin
          st_e[EV_HOOK_OFF] = 1'b1;
          hf_e = 1'b0;
          hold_e = 1'b0;
        end
      end
    endcase
  endtask

  task automatic check_pins;
    @(negedge clk);
    chk({31'h0, line_pwr}, {31'h0, exp_po()});
    chk({31'h0, hf_o}, {31'h0, hf_e});
    chk({31'h0, hold_o}, {31'h0, hold_e});
    chk({31'h0, irq}, {31'h0, |(st_e & mask_e)});
    chk({31'h0, mute_oe}, {31'h0, mute_e});
    chk({31'h0, lsw_oe}, {31'h0, lsw_e});
    @(posedge clk);
  endtask

  task automatic ev(input int kind);
    int w;
    w = 1 + {$random(seed)} % 3;
    case (kind)
      0: lm.press_hf(w);
      1: lm.press_hold(w);
      default: lm.set_hook(~hook_lvl);
    endcase
    repeat (6) @(posedge clk);
    model_ev(kind);
    check_pins;
    rd_chk(OFS_IRQ_STAT, {28'h0, st_e}, 32'h0000_000F);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hf_e, hold_e, auto_e, mute_e, lsw_e} = 5'h00;
    {hook_lvl, hook_on} = 2'h3;
    st_e = 4'h0;
    mask_e = 4'h0;
    mode_e = PM_NORMAL;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFS_DIAL_IO, 32'h0000_0314, 32'h0000_033F);
    rd_chk(OFS_IRQ_VEC, {24'h0, DIALER_VECTOR}, 32'hFFFF_FFFF);
    wr(32'h0000_0020, 32'hFFFF_FFFF);
    rd_chk(32'h0000_0020, 32'h0000_0000, 32'hFFFF_FFFF);
    rd_chk(OFS_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    check_pins;
    set_io(1'b0, 1'b1, 1'b0);
    rd_chk(OFS_DIAL_IO, 32'h0000_0100, 32'h0000_0300);
    set_io(1'b0, 1'b0, 1'b1);
    rd_chk(OFS_DIAL_IO, 32'h0000_0200, 32'h0000_0300);
    ev(2);
    set_io(1'b1, 1'b1, 1'b1);
    check_pins;
    ev(2);
    wr(OFS_IRQ_STAT, 32'h0000_000F);
    st_e = 4'h0;
    wr(OFS_IRQ_MASK, 32'h0000_000F);
    mask_e = 4'hF;
    check_pins;
    // awkward order: ignored hold, hold across a hook rise, then hold on-hook
    foreach (dseq[i]) ev(dseq[i]);
    for (int i = 0; i < 80; i++) begin
      if (i % 8 == 0) begin
        mask_e = $random(seed);
        wr(OFS_IRQ_MASK, {28'h0, mask_e});
        mode_e = $random(seed);
        wr(OFS_PWR_MODE, {30'h0, mode_e});
        set_io(($random(seed) & 3) != 0, $random(seed), $random(seed));
      end
      ev({$random(seed)} % 3);
      if ($random(seed) & 1) begin
        wr(OFS_IRQ_STAT, {28'h0, st_e});
        st_e = 4'h0;
        check_pins;
      end
    end
    tally_and_finish;
  end

  initial begin
    #400_000;
    n_fail++;
    tally_and_finish;
  end
endmodule
